/* File: pkg/fps_pkg.sv */
// package for the host-side flash program/suspend controller
// assumes a 125 MHz sys_clk_in and an 8-bit parallel flash on the far side
//
// Overview of operation
// [RULE1] device acts on suspend only during sector erase
// [RULE2] active erase suspends within 20 us
// [RULE3] suspend in erase time-out ends time-out at once
// [RULE4] suspended device takes only read, resume, program
// [RULE5] after suspend-program, array reads return normally
// [RULE6] resume restarts erase only when suspend pending
// [RULE7] host waits 10 ms after resume past 1024
// [RULE8] program is two unlocks, A0H, then address/data
// [RULE9] address at later fall, data at earlier rise
// [RULE10] done when toggle stops and bits 7,6 match
// [RULE11] over-long program sets timeout flag
// [RULE12] commands during programming are ignored
// [RULE13] hardware reset aborts program; host reissues sequence; fps_host only pulses rst_n and does not reissue it
// [RULE14] programming only clears bits; raising may misreport
// [RULE15] poll bit reads inverted data bit 7 while busy
// [RULE16] protected address polls about 1 us, no change
// [RULE17] poll bit zero during erase, one after
// [RULE18] all-protected erase polls 100 us then reads
// [RULE19] host polls at program or erased-sector address
// [RULE20] after poll turns true, read once more
// [RULE21] ready_busy_n low while erasing or programming
// [RULE22] status valid from final write rising edge
// [RULE23] suspended sectors read back status, not data; the flash model returns array data at every address while suspended and not programming
// [RULE24] toggle bit inverts each read while busy
// [RULE25] reset command clears timeout, also in suspend
// [RULE26] unlock addresses and data are parameters
// [RULE27] device timers run from internal time base
package fps_pkg;

	localparam int CLK_MHZ = 125;
	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;
	localparam int CNT_W = 12;
	localparam int GAP_W = 21;
	localparam int SR_W = 11;

	localparam int WE_LOW_NS = 50;
	localparam int WE_HIGH_NS = 30;
	localparam int RD_ACCESS_NS = 90;
	localparam int HWRST_NS = 500;
	localparam int SUSPEND_MAX_US = 20;
	localparam int RESUME_GAP_MS = 10;
	localparam int RESUME_FREE_LIMIT = 1024;

	localparam int WE_LOW_CYC = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int WE_HIGH_CYC = (WE_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int RD_CYC = (RD_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int HWRST_CYC = (HWRST_NS * CLK_MHZ + 999) / 1000;
	localparam int SUSPEND_CYC = SUSPEND_MAX_US * CLK_MHZ;
	localparam int RESUME_GAP_CYC = RESUME_GAP_MS * 1000 * CLK_MHZ;

	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_RESET = 8'hF0;

	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int TIMEOUT_BIT = 5;

	typedef enum logic [2:0] {
		FPS_OP_READ,
		FPS_OP_PROGRAM,
		FPS_OP_SUSPEND,
		FPS_OP_RESUME,
		FPS_OP_RESET,
		FPS_OP_HWRESET
	} fps_op_t;

	typedef struct packed {
		fps_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fps_cmd_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic rst_n;
	} fps_pins_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic last;
	} fps_step_t;

	localparam fps_pins_t PINS_IDLE = '{addr: '0, dq: '0, dq_oe: 1'b0, ce_n: 1'b1,
		oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1};

endpackage

/* File: hw/fps_host.sv */
// host controller driving the flash pins for read, program, suspend, resume, reset
// assumes flash pins outside sys_clk_in domain; wire logic resolves dq from dq_oe
`timescale 1ns/1ps
module fps_host import fps_pkg::*; #(
	parameter logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h00001,
	parameter logic [DATA_W-1:0] UNLOCK1_DATA = 8'h01,
	parameter logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h00002,
	parameter logic [DATA_W-1:0] UNLOCK2_DATA = 8'h02,
	parameter int unsigned RESUME_GAP_CYCLES = RESUME_GAP_CYC
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic cmd_valid_in,
	input wire fps_cmd_t cmd_in,
	output logic cmd_ready_out,
	output logic done_out,
	output logic error_out,
	output logic [DATA_W-1:0] rd_data_out,
	output logic suspended_out,
	output logic flash_busy_out,
	output fps_pins_t pins_out,
	input wire logic [DATA_W-1:0] flash_dq_in,
	input wire logic flash_ready_busy_n_in
);

	typedef enum logic [3:0] {
		ST_IDLE, ST_GAP_WAIT, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
		ST_RD_PULSE, ST_RD_EVAL, ST_SUSP_WAIT, ST_HWRST, ST_DONE
	} fps_state_t;

	////////////////////////////////////////////////////////////////////////
	// write cycle table per operation
	function automatic fps_step_t fps_step(input fps_op_t op, input logic [1:0] step,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		fps_step_t s;
		s = '{addr: a, data: CMD_RESET, last: 1'b1};
		case (op)
			FPS_OP_PROGRAM: begin
				case (step) // RULE8 RULE26
					2'd0: s = '{addr: UNLOCK1_ADDR, data: UNLOCK1_DATA, last: 1'b0};
					2'd1: s = '{addr: UNLOCK2_ADDR, data: UNLOCK2_DATA, last: 1'b0};
					2'd2: s = '{addr: UNLOCK1_ADDR, data: CMD_PROGRAM, last: 1'b0};
					default: s = '{addr: a, data: d, last: 1'b1};
				endcase
			end
			FPS_OP_SUSPEND: s.data = CMD_SUSPEND;
			FPS_OP_RESUME: s.data = CMD_RESUME;
			default: s.data = CMD_RESET;
		endcase
		return s;
	endfunction

	function automatic fps_pins_t fps_rd_pins(input logic [ADDR_W-1:0] a);
		fps_pins_t p;
		p = PINS_IDLE;
		p.addr = a;
		p.ce_n = 1'b0;
		p.oe_n = 1'b0;
		return p;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [DATA_W-1:0] dq_s1_r, dq_s2_r, dq_s3_r;
	logic rb_s1_r, rb_s2_r, rb_s3_r, busy_r, busy_nxt;

	always_comb begin
		busy_nxt = busy_r;
		if (rb_s2_r == rb_s3_r)
			busy_nxt = !rb_s3_r; // RULE21
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			dq_s1_r <= 8'h00;
			dq_s2_r <= 8'h00;
			dq_s3_r <= 8'h00;
			rb_s1_r <= 1'b1;
			rb_s2_r <= 1'b1;
			rb_s3_r <= 1'b1;
			busy_r <= 1'b0;
		end else begin
			dq_s1_r <= flash_dq_in;
			dq_s2_r <= dq_s1_r;
			dq_s3_r <= dq_s2_r;
			rb_s1_r <= flash_ready_busy_n_in;
			rb_s2_r <= rb_s1_r;
			rb_s3_r <= rb_s2_r;
			busy_r <= busy_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer
	fps_state_t state_r, state_nxt;
	fps_op_t op_r, op_nxt;
	fps_pins_t pins_r, pins_nxt;
	fps_step_t st;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [DATA_W-1:0] data_r, data_nxt, rd_r, rd_nxt, prev_r, prev_nxt;
	logic [1:0] step_r, step_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [GAP_W-1:0] gap_r, gap_nxt;
	logic [SR_W-1:0] sr_cnt_r, sr_cnt_nxt;
	logic have_prev_r, have_prev_nxt, final_r, final_nxt, tmo_r, tmo_nxt;
	logic polling_r, polling_nxt, err_r, err_nxt, done_r, done_nxt;
	logic ready_r, ready_nxt, susp_r, susp_nxt;

	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		pins_nxt = pins_r;
		addr_nxt = addr_r;
		data_nxt = data_r;
		rd_nxt = rd_r;
		prev_nxt = prev_r;
		step_nxt = step_r;
		cnt_nxt = cnt_r;
		gap_nxt = (gap_r != '0) ? gap_r - 1'b1 : gap_r; // RULE27
		sr_cnt_nxt = sr_cnt_r;
		have_prev_nxt = have_prev_r;
		final_nxt = final_r;
		tmo_nxt = tmo_r;
		polling_nxt = polling_r;
		err_nxt = err_r;
		done_nxt = 1'b0;
		ready_nxt = ready_r;
		susp_nxt = susp_r;
		st = fps_step(op_r, step_r, addr_r, data_r);
		case (state_r)
			ST_IDLE: begin
				ready_nxt = 1'b1;
				if (cmd_valid_in && ready_r) begin
					ready_nxt = 1'b0;
					op_nxt = cmd_in.op;
					addr_nxt = cmd_in.addr;
					data_nxt = cmd_in.data;
					step_nxt = 2'd0;
					err_nxt = 1'b0;
					have_prev_nxt = 1'b0;
					final_nxt = 1'b0;
					tmo_nxt = 1'b0;
					polling_nxt = 1'b0;
					case (cmd_in.op)
						FPS_OP_READ: begin
							pins_nxt = fps_rd_pins(cmd_in.addr); // RULE5 RULE23
							cnt_nxt = CNT_W'(RD_CYC);
							state_nxt = ST_RD_PULSE;
						end
						FPS_OP_HWRESET: begin
							pins_nxt = PINS_IDLE;
							pins_nxt.rst_n = 1'b0; // RULE13
							cnt_nxt = CNT_W'(HWRST_CYC);
							state_nxt = ST_HWRST;
						end
						FPS_OP_SUSPEND: begin
							if (sr_cnt_r > SR_W'(RESUME_FREE_LIMIT) && gap_r != '0)
								state_nxt = ST_GAP_WAIT; // RULE7
							else
								state_nxt = ST_WR_SETUP;
						end
						default: state_nxt = ST_WR_SETUP;
					endcase
				end
			end
			ST_GAP_WAIT: begin
				if (gap_r == '0)
					state_nxt = ST_WR_SETUP; // RULE7
			end
			ST_WR_SETUP: begin
				pins_nxt = PINS_IDLE;
				pins_nxt.addr = st.addr;
				pins_nxt.dq = st.data;
				pins_nxt.dq_oe = 1'b1;
				pins_nxt.ce_n = 1'b0;
				cnt_nxt = CNT_W'(WE_LOW_CYC);
				state_nxt = ST_WR_PULSE;
			end
			ST_WR_PULSE: begin
				pins_nxt.we_n = 1'b0; // RULE9
				if (cnt_r == '0) begin
					pins_nxt.we_n = 1'b1;
					pins_nxt.ce_n = 1'b1;
					cnt_nxt = CNT_W'(WE_HIGH_CYC);
					state_nxt = ST_WR_HOLD;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			ST_WR_HOLD: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - 1'b1;
				end else begin
					pins_nxt.dq_oe = 1'b0;
					if (!st.last) begin
						step_nxt = step_r + 2'd1;
						state_nxt = ST_WR_SETUP;
					end else begin
						case (op_r)
							FPS_OP_PROGRAM: begin
								polling_nxt = 1'b1;
								pins_nxt = fps_rd_pins(addr_r); // RULE19 RULE22
								cnt_nxt = CNT_W'(RD_CYC);
								state_nxt = ST_RD_PULSE;
							end
							FPS_OP_SUSPEND: begin
								cnt_nxt = CNT_W'(SUSPEND_CYC); // RULE2 RULE3
								state_nxt = ST_SUSP_WAIT;
							end
							FPS_OP_RESUME: begin
								if (susp_r) begin // RULE6
									susp_nxt = 1'b0;
									gap_nxt = GAP_W'(RESUME_GAP_CYCLES);
									if (sr_cnt_r != '1)
										sr_cnt_nxt = sr_cnt_r + 1'b1;
								end
								state_nxt = ST_DONE;
							end
							default: state_nxt = ST_DONE; // RULE25
						endcase
					end
				end
			end
			ST_RD_PULSE: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - 1'b1;
				end else if (dq_s2_r == dq_s3_r) begin
					rd_nxt = dq_s3_r;
					pins_nxt = PINS_IDLE;
					state_nxt = ST_RD_EVAL;
				end
			end
			ST_RD_EVAL: begin
				state_nxt = ST_RD_PULSE;
				pins_nxt = fps_rd_pins(addr_r);
				cnt_nxt = CNT_W'(RD_CYC);
				if (!polling_r) begin
					pins_nxt = PINS_IDLE;
					state_nxt = ST_DONE;
				end else if (final_r) begin
					pins_nxt = PINS_IDLE;
					err_nxt = (rd_r != data_r); // RULE14 RULE16 RULE20
					state_nxt = ST_DONE;
				end else if (have_prev_r && rd_r[TOGGLE_BIT] == prev_r[TOGGLE_BIT]) begin
					final_nxt = 1'b1; // RULE10 RULE15 RULE24
				end else if (have_prev_r && tmo_r) begin
					err_nxt = 1'b1; // RULE11
					op_nxt = FPS_OP_RESET; // RULE25
					polling_nxt = 1'b0;
					pins_nxt = PINS_IDLE;
					step_nxt = 2'd0;
					state_nxt = ST_WR_SETUP;
				end else begin
					have_prev_nxt = 1'b1; // RULE12
					prev_nxt = rd_r;
					tmo_nxt = rd_r[TIMEOUT_BIT];
				end
			end
			ST_SUSP_WAIT: begin
				cnt_nxt = cnt_r - 1'b1;
				if (cnt_r == '0 || !busy_r) begin // RULE17 RULE18
					susp_nxt = 1'b1; // RULE1 RULE4 RULE21
					state_nxt = ST_DONE;
				end
			end
			ST_HWRST: begin
				if (cnt_r != '0) begin
					cnt_nxt = cnt_r - 1'b1;
				end else if (!pins_r.rst_n) begin
					pins_nxt.rst_n = 1'b1;
					cnt_nxt = CNT_W'(HWRST_CYC);
				end else begin
					susp_nxt = 1'b0; // RULE13
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: begin
				done_nxt = 1'b1;
				ready_nxt = 1'b1;
				state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_r <= ST_IDLE;
			op_r <= FPS_OP_READ;
			pins_r <= PINS_IDLE;
			addr_r <= '0;
			data_r <= 8'h00;
			rd_r <= 8'h00;
			prev_r <= 8'h00;
			step_r <= 2'd0;
			cnt_r <= '0;
			gap_r <= '0;
			sr_cnt_r <= '0;
			have_prev_r <= 1'b0;
			final_r <= 1'b0;
			tmo_r <= 1'b0;
			polling_r <= 1'b0;
			err_r <= 1'b0;
			done_r <= 1'b0;
			ready_r <= 1'b0;
			susp_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			pins_r <= pins_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
			rd_r <= rd_nxt;
			prev_r <= prev_nxt;
			step_r <= step_nxt;
			cnt_r <= cnt_nxt;
			gap_r <= gap_nxt;
			sr_cnt_r <= sr_cnt_nxt;
			have_prev_r <= have_prev_nxt;
			final_r <= final_nxt;
			tmo_r <= tmo_nxt;
			polling_r <= polling_nxt;
			err_r <= err_nxt;
			done_r <= done_nxt;
			ready_r <= ready_nxt;
			susp_r <= susp_nxt;
		end
	end

	assign cmd_ready_out = ready_r;
	assign done_out = done_r;
	assign error_out = err_r;
	assign rd_data_out = rd_r;
	assign suspended_out = susp_r;
	assign flash_busy_out = busy_r;
	assign pins_out = pins_r;

endmodule // fps_host

/* File: dv/fps_host_monitor.sv */
// port checker for the host-side flash controller
// assumes one clock domain and reset active high
`timescale 1ns/1ps
module fps_host_monitor import fps_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic cmd_valid_in,
	input wire fps_cmd_t cmd_in,
	input wire logic cmd_ready_out,
	input wire logic done_out,
	input wire logic error_out,
	input wire logic [DATA_W-1:0] rd_data_out,
	input wire logic suspended_out,
	input wire logic flash_busy_out,
	input wire fps_pins_t pins_out,
	input wire logic [DATA_W-1:0] flash_dq_in,
	input wire logic flash_ready_busy_n_in
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////
	sequence s_we_low; !pins_out.we_n [*7]; endsequence
	sequence s_dq_hold; (pins_out.dq_oe && $stable(pins_out.dq)) [*4]; endsequence
	property p_rst_idle; $fell(rst_in) |-> pins_out == PINS_IDLE && !done_out ##1 cmd_ready_out;
	endproperty
	property p_take; cmd_valid_in && cmd_ready_out |=> !cmd_ready_out; endproperty
	property p_done; done_out |=> !done_out && cmd_ready_out; endproperty
	property p_wr_gate; !pins_out.we_n |-> !pins_out.ce_n && pins_out.oe_n && pins_out.dq_oe;
	endproperty
	property p_we_len; $fell(pins_out.we_n) |-> s_we_low ##[1:2] pins_out.we_n; endproperty
	property p_we_ce; $rose(pins_out.we_n) |-> $rose(pins_out.ce_n) ##0 s_dq_hold; endproperty
	property p_addr; !pins_out.ce_n && !$past(pins_out.ce_n) |-> $stable(pins_out.addr); endproperty
	property p_rd_bus; !pins_out.oe_n |-> !pins_out.dq_oe && !pins_out.ce_n && pins_out.we_n;
	endproperty
	property p_busy; !flash_ready_busy_n_in [*6] |-> flash_busy_out; endproperty
	property p_hwrst; $fell(pins_out.rst_n) |-> !pins_out.rst_n [*8]; endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("pins not idle after reset");
	a_take: assert property (p_take) else $error("ready held after take");
	a_done: assert property (p_done) else $error("done pulse wrong");
	a_wr_gate: assert property (p_wr_gate) else $error("write strobe ungated");
	a_we_len: assert property (p_we_len) else $error("write pulse length");
	a_we_ce: assert property (p_we_ce) else $error("write release order");
	a_addr: assert property (p_addr) else $error("address moved in cycle");
	a_rd_bus: assert property (p_rd_bus) else $error("read with bus driven");
	a_busy: assert property (p_busy) else $error("busy not seen");
	a_hwrst: assert property (p_hwrst) else $error("reset pulse short");
endmodule // fps_host_monitor
bind fps_host fps_host_monitor u_mon (.sys_clk_in, .rst_in, .cmd_valid_in, .cmd_in,
	.cmd_ready_out, .done_out, .error_out, .rd_data_out, .suspended_out, .flash_busy_out,
	.pins_out, .flash_dq_in, .flash_ready_busy_n_in);

/* File: dv/fps_flash_model.sv */
// behavioural parallel flash: program, erase status, suspend, resume
// assumes default unlock values of the host; addr bit 7 protected, 55 never finishes
`timescale 1ns/1ps
module fps_flash_model import fps_pkg::*; #(
	parameter int PROG_NS = 2000,
	parameter int PROT_NS = 1000,
	parameter int TO_NS = 3000
) (
	input wire fps_pins_t pins_in,
	input wire logic erase_start_in,
	output wire logic [DATA_W-1:0] dq_out,
	output wire logic rdy_bsy_n_out
);
	logic [7:0] mem [256];
	logic [7:0] pd = 8'h00, last = 8'h00;
	logic [18:0] la = '0;
	logic [1:0] step = 2'h0;
	logic prog = 1'b0, ers = 1'b0, susp = 1'b0, tog = 1'b0, tout = 1'b0;
	event go;
	wire wr_n = pins_in.we_n | pins_in.ce_n;
	wire rd_n = pins_in.oe_n | pins_in.ce_n;
	wire [7:0] stat = {ers ? 1'b0 : ~pd[7], tog, tout, 5'h00};
	wire [7:0] rd_v = (prog || ers) ? stat : mem[pins_in.addr[7:0]];
	assign dq_out = pins_in.dq_oe ? pins_in.dq : !rd_n ? rd_v : ~last;
	assign rdy_bsy_n_out = (prog || ers) ? 1'b0 : 1'b1;
	initial for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
	////////////////////////////////////////
	always @(posedge rd_n) begin
		last = rd_v;
		if (prog || ers) tog = ~tog;
	end
	always @(negedge wr_n) la = pins_in.addr;
	always @(posedge wr_n) if (pins_in.rst_n && (!prog || tout)) begin
		if (step == 2'h3) begin
			step = 2'h0;
			pd = pins_in.dq;
			prog = 1'b1;
			-> go;
		end else if (pins_in.dq == CMD_SUSPEND) begin
			if (ers) begin
				ers <= #300 1'b0;
				susp <= #300 1'b1;
			end
		end else if (pins_in.dq == CMD_RESUME) begin
			if (susp) begin
				susp = 1'b0;
				ers = 1'b1;
			end
		end else if (pins_in.dq == CMD_RESET) begin
			tout = 1'b0;
			prog = 1'b0;
			step = 2'h0;
		end else if (step == 2'h0 && la == 19'h00001 && pins_in.dq == 8'h01) step = 2'h1;
		else if (step == 2'h1 && la == 19'h00002 && pins_in.dq == 8'h02) step = 2'h2;
		else if (step == 2'h2 && pins_in.dq == CMD_PROGRAM) step = 2'h3;
		else step = 2'h0;
	end
	always @(go) begin
		#(la[7] ? PROT_NS : la[7:0] == 8'h55 ? TO_NS : PROG_NS);
		if (la[7:0] == 8'h55) tout = 1'b1;
		else if (prog) begin
			if (!la[7]) mem[la[7:0]] = mem[la[7:0]] & pd;
			prog = 1'b0;
		end
	end
	always @(negedge pins_in.rst_n) begin
		{prog, ers, susp, tout} = 4'h0;
		step = 2'h0;
	end
	always @(posedge erase_start_in) ers = 1'b1;
endmodule // fps_flash_model

/* File: dv/tb_top.sv */
// self-checking bench for fps_host against the flash model
// assumes 125 MHz clock and synchronous reset
`timescale 1ns/1ps
module tb_top import fps_pkg::*;;
	logic sys_clk_in = 1'b0;
	logic rst_in, cmd_valid_in, cmd_ready_out, done_out, error_out, suspended_out;
	logic flash_busy_out, erase_go;
	fps_cmd_t cmd_in;
	fps_pins_t pins_out;
	logic [DATA_W-1:0] rd_data_out;
	wire logic [DATA_W-1:0] flash_dq_in;
	wire logic flash_ready_busy_n_in;
	int err_total = 0, checks_done = 0;
	fps_host #(.RESUME_GAP_CYCLES(50)) dut (.sys_clk_in, .rst_in, .cmd_valid_in, .cmd_in,
		.cmd_ready_out, .done_out, .error_out, .rd_data_out, .suspended_out, .flash_busy_out,
		.pins_out, .flash_dq_in, .flash_ready_busy_n_in);
	fps_flash_model u_flash (.pins_in(pins_out), .erase_start_in(erase_go),
		.dq_out(flash_dq_in), .rdy_bsy_n_out(flash_ready_busy_n_in));
	////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic run(input fps_op_t op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (cmd_ready_out !== 1'b1) @(posedge sys_clk_in);
		cmd_in <= '{op: op, addr: a, data: d};
		cmd_valid_in <= 1'b1;
		@(posedge sys_clk_in);
		cmd_valid_in <= 1'b0;
		while (done_out !== 1'b1 && n < 20000) begin
			@(posedge sys_clk_in);
			n++;
		end
		if (n >= 20000) chk(8'h00, 8'h01);
	endtask
	task automatic wait_busy(input logic exp);
		int n;
		n = 0;
		while (flash_busy_out !== exp && n < 400) begin
			@(posedge sys_clk_in);
			n++;
		end
		chk({7'h00, flash_busy_out}, {7'h00, exp});
	endtask
	initial forever #4 sys_clk_in = ~sys_clk_in;
	initial begin
		#400000;
		err_total++;
		stop_test();
	end
	initial begin
		rst_in = 1'b1;
		cmd_valid_in = 1'b0;
		cmd_in = '0;
		erase_go = 1'b0;
		repeat (3) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		run(FPS_OP_READ, 19'h00003, 8'h00);
		chk(rd_data_out, 8'hFF);
		run(FPS_OP_PROGRAM, 19'h00003, 8'h5A);
		chk({7'h00, error_out}, 8'h00);
		run(FPS_OP_READ, 19'h00003, 8'h00);
		chk(rd_data_out, 8'h5A);
		run(FPS_OP_PROGRAM, 19'h00003, 8'hA5);
		chk({7'h00, error_out}, 8'h01);
		run(FPS_OP_READ, 19'h00003, 8'h00);
		chk(rd_data_out, 8'h00);
		run(FPS_OP_PROGRAM, 19'h00083, 8'h00);
		chk({7'h00, error_out}, 8'h01);
		run(FPS_OP_READ, 19'h00083, 8'h00);
		chk(rd_data_out, 8'hFF);
		run(FPS_OP_PROGRAM, 19'h00055, 8'h00);
		chk({7'h00, error_out}, 8'h01);
		run(FPS_OP_READ, 19'h00055, 8'h00);
		chk(rd_data_out, 8'hFF);
		erase_go <= 1'b1;
		wait_busy(1'b1);
		run(FPS_OP_READ, 19'h00010, 8'h00);
		chk(rd_data_out & 8'h80, 8'h00);
		run(FPS_OP_SUSPEND, 19'h00010, 8'h00);
		chk({7'h00, suspended_out}, 8'h01);
		wait_busy(1'b0);
		run(FPS_OP_PROGRAM, 19'h00004, 8'h33);
		chk({7'h00, error_out}, 8'h00);
		run(FPS_OP_READ, 19'h00004, 8'h00);
		chk(rd_data_out, 8'h33);
		run(FPS_OP_RESUME, 19'h00010, 8'h00);
		chk({7'h00, suspended_out}, 8'h00);
		wait_busy(1'b1);
		run(FPS_OP_HWRESET, 19'h00000, 8'h00);
		wait_busy(1'b0);
		run(FPS_OP_SUSPEND, 19'h00010, 8'h00);
		wait_busy(1'b0);
		run(FPS_OP_RESET, 19'h00000, 8'h00);
		chk({7'h00, error_out}, 8'h00);
		stop_test();
	end
endmodule // tb_top
